/* File: logic/rec_consts.vh */
// Purpose: constants for the regulator enable and discharge configuration slice
// Assumes: 8-bit registers at byte offsets of the serial control port
// Notes: otp defaults arrive on input ports and load on power-on reset
`ifndef REC_CONSTS_VH
`define REC_CONSTS_VH
`define REC_ADDR_SOURCE    8'h2C
`define REC_ADDR_DIS_LOW   8'h2D
`define REC_ADDR_DIS_HIGH  8'h2E
`define REC_ADDR_MASK_LOW  8'h2F
`define REC_ADDR_MASK_HIGH 8'h30
`define REC_HIGH_USED      8'h3F
`define REC_SRC_LSB        0
`define REC_SRC_MSB        1
`define REC_SYNC_STAGES    3
`endif

/* File: logic/rec_regulator_config.v */
// Purpose: source select, discharge enables and pin-one masks for the regulators
// Assumes: serial port decodes to a byte write strobe and a byte address
// Notes: defaults are sampled from otp ports in the first clock after reset release
`timescale 1ns/1ns
`include "rec_consts.vh"
module rec_regulator_config (
  input  wire       clk,              // 100 MHz clock
  input  wire       nrst,             // power-on reset, active low
  input  wire       wrEn,             // register write strobe, one cycle
  input  wire       rdEn,             // register read strobe, one cycle
  input  wire [7:0] addr,             // register byte address
  input  wire [7:0] wrData,           // write data
  output reg  [7:0] rdData,           // read data, registered
  output reg        rdValid,          // read data valid, one cycle
  input  wire [1:0] otpSource,        // otp default of source field
  input  wire [7:0] otpDisLow,        // otp default, low discharge
  input  wire [7:0] otpDisHigh,       // otp default, high discharge
  input  wire [7:0] otpMaskLow,       // otp default, low mask
  input  wire [7:0] otpMaskHigh,      // otp default, high mask
  input  wire [3:0] voltageSelectPin, // raw voltage-select pins, buck1..4
  input  wire       enablePinOne,     // raw enable pin one
  output reg        reg1DefaultVoltageChoice, // 0 operating, 1 alternate
  output reg        reg1UseAlternate,         // alternate register selected
  output reg  [9:0] regOutputPulldown,        // regulators 1..10 discharge enables
  output reg  [3:0] buckOutputPulldown,       // bucks 1..4 discharge enables
  output reg  [9:0] regPinOneEnable,          // pin one drive, regulators 1..10
  output reg  [3:0] buckPinOneEnable,         // pin one drive, bucks 1..4
  output reg  [9:0] regPinOneControl,         // mask bits, regulators
  output reg  [3:0] buckPinOneControl         // mask bits, bucks
);
  // one-hot load sequencer: the otp copy runs once per power-on reset and again after an illegal state code
  localparam [1:0] ST_LOAD = 2'h1;
  localparam [1:0] ST_RUN  = 2'h2;

  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg  [1:0] source_r;
  reg  [1:0] source_nxt;
  reg  [7:0] disLow_r;
  reg  [7:0] disLow_nxt;
  reg  [5:0] disHigh_r;
  reg  [5:0] disHigh_nxt;
  reg  [7:0] maskLow_r;
  reg  [7:0] maskLow_nxt;
  reg  [5:0] maskHigh_r;
  reg  [5:0] maskHigh_nxt;
  reg  [7:0] rdData_nxt;
  wire       wrSource;
  wire       wrDisLow;
  wire       wrDisHigh;
  wire       wrMaskLow;
  wire       wrMaskHigh;
  wire [3:0] selSync;
  wire       pinOneSync;
  wire       selPin;
  wire [9:0] regPulldown_nxt;
  wire [3:0] buckPulldown_nxt;
  wire [9:0] regControl_nxt;
  wire [3:0] buckControl_nxt;
  wire [9:0] regEnable_nxt;
  wire [3:0] buckEnable_nxt;
  genvar     gi;

  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : gSel
      rec_sync #(.RESET_VAL(1'b0)) uSel (
        .clk      (clk),
        .nrst     (nrst),
        .pinIn    (voltageSelectPin[gi]),
        .levelOut (selSync[gi])
      );
    end
  endgenerate

  rec_sync #(.RESET_VAL(1'b0)) uPinOne (
    .clk      (clk),
    .nrst     (nrst),
    .pinIn    (enablePinOne),
    .levelOut (pinOneSync)
  );

  // filtered pins only, so a source rewrite never meets a raw pin
  assign selPin = selSync[source_r];

  // writes in the otp copy cycle are dropped by the sequencer, not here
  assign wrSource   = wrEn & (addr == `REC_ADDR_SOURCE);
  assign wrDisLow   = wrEn & (addr == `REC_ADDR_DIS_LOW);
  assign wrDisHigh  = wrEn & (addr == `REC_ADDR_DIS_HIGH);
  assign wrMaskLow  = wrEn & (addr == `REC_ADDR_MASK_LOW);
  assign wrMaskHigh = wrEn & (addr == `REC_ADDR_MASK_HIGH);

  // next state and register writes
  always @* begin
    state_nxt    = state_r;
    source_nxt   = source_r;
    disLow_nxt   = disLow_r;
    disHigh_nxt  = disHigh_r;
    maskLow_nxt  = maskLow_r;
    maskHigh_nxt = maskHigh_r;
    case (state_r)
      ST_LOAD: begin
        state_nxt    = ST_RUN;
        source_nxt   = otpSource;
        disLow_nxt   = otpDisLow;
        disHigh_nxt  = otpDisHigh[5:0];
        maskLow_nxt  = otpMaskLow;
        maskHigh_nxt = otpMaskHigh[5:0];
      end
      ST_RUN: begin
        if (wrSource) begin
          source_nxt = wrData[`REC_SRC_MSB:`REC_SRC_LSB];
        end
        if (wrDisLow) begin
          disLow_nxt = wrData;
        end
        if (wrDisHigh) begin
          disHigh_nxt = wrData[5:0];
        end
        if (wrMaskLow) begin
          maskLow_nxt = wrData;
        end
        if (wrMaskHigh) begin
          maskHigh_nxt = wrData[5:0];
        end
      end
      default: begin
        // an illegal code redoes the copy rather than run half loaded
        state_nxt = ST_LOAD;
      end
    endcase
  end

  // reset branch holds constants; otp values enter through ST_LOAD
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r    <= ST_LOAD;
      source_r   <= 2'h0;
      disLow_r   <= 8'h00;
      disHigh_r  <= 6'h00;
      maskLow_r  <= 8'h00;
      maskHigh_r <= 6'h00;
    end else begin
      state_r    <= state_nxt;
      source_r   <= source_nxt;
      disLow_r   <= disLow_nxt;
      disHigh_r  <= disHigh_nxt;
      maskLow_r  <= maskLow_nxt;
      maskHigh_r <= maskHigh_nxt;
    end
  end

  // read data holds until the next read
  always @* begin
    rdData_nxt = rdData;
    if (rdEn) begin
      case (addr)
        `REC_ADDR_SOURCE:    rdData_nxt = {6'h00, source_r};
        `REC_ADDR_DIS_LOW:   rdData_nxt = disLow_r;
        `REC_ADDR_DIS_HIGH:  rdData_nxt = {2'h0, disHigh_r} & `REC_HIGH_USED;
        `REC_ADDR_MASK_LOW:  rdData_nxt = maskLow_r;
        `REC_ADDR_MASK_HIGH: rdData_nxt = {2'h0, maskHigh_r} & `REC_HIGH_USED;
        default:             rdData_nxt = 8'h00;
      endcase
    end
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData  <= 8'h00;
      rdValid <= 1'h0;
    end else begin
      rdData  <= rdData_nxt;
      rdValid <= rdEn;
    end
  end

  // regulators 1..8 sit in the low registers, 9..10 and the bucks in the high ones
  assign regPulldown_nxt  = {disHigh_r[1:0], disLow_r};
  assign buckPulldown_nxt = disHigh_r[5:2];
  assign regControl_nxt   = {maskHigh_r[1:0], maskLow_r};
  assign buckControl_nxt  = maskHigh_r[5:2];
  assign regEnable_nxt    = regControl_nxt & {10{pinOneSync}};
  assign buckEnable_nxt   = buckControl_nxt & {4{pinOneSync}};

  // both choice outputs are one level seen twice; they cannot disagree
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg1DefaultVoltageChoice <= 1'h0;
      reg1UseAlternate         <= 1'h0;
    end else begin
      reg1DefaultVoltageChoice <= selPin;
      reg1UseAlternate         <= (selPin == 1'h1);
    end
  end

  // discharge enables are plain levels for the analog side
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regOutputPulldown  <= 10'h000;
      buckOutputPulldown <= 4'h0;
    end else begin
      regOutputPulldown  <= regPulldown_nxt;
      buckOutputPulldown <= buckPulldown_nxt;
    end
  end

  // pin drive lags the filtered pin by one clock; the masks lag a write by one
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regPinOneControl  <= 10'h000;
      buckPinOneControl <= 4'h0;
      regPinOneEnable   <= 10'h000;
      buckPinOneEnable  <= 4'h0;
    end else begin
      regPinOneControl  <= regControl_nxt;
      buckPinOneControl <= buckControl_nxt;
      regPinOneEnable   <= regEnable_nxt;
      buckPinOneEnable  <= buckEnable_nxt;
    end
  end
endmodule // rec_regulator_config

/* File: logic/rec_sync.v */
// Purpose: three-stage synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes: output changes once stages two and three agree
`timescale 1ns/1ns
module rec_sync #(
  parameter RESET_VAL = 1'b0
) (
  input  wire clk,      // system clock
  input  wire nrst,     // async reset, active low
  input  wire pinIn,    // raw pin level
  output reg  levelOut  // filtered level
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r     <= RESET_VAL;
      s2_r     <= RESET_VAL;
      s3_r     <= RESET_VAL;
      levelOut <= RESET_VAL;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        levelOut <= s3_r;
      end
    end
  end
endmodule // rec_sync

/* File: tb/rec_host_model.sv */
// Purpose: host side of the serial control port
// Assumes: strobes move on the falling edge. Notes: a read waits four cycles at most
`timescale 1ns/1ns
module rec_host_model (
  input  wire       clk,    // clock
  output reg        wrEn,   // write strobe
  output reg        rdEn,   // read strobe
  output reg  [7:0] addr,   // address
  output reg  [7:0] wrData, // write data
  input  wire [7:0] rdData, // read data
  input  wire       rdValid // read valid
);
  initial {wrEn, rdEn, addr, wrData} = 18'h0_0000;
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk) {wrEn, addr, wrData} = {1'b1, a, d};
      @(negedge clk) wrEn = 1'b0;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    integer i;
    begin
      @(negedge clk) {rdEn, addr} = {1'b1, a};
      @(negedge clk) rdEn = 1'b0;
      for (i = 0; i < 4 && rdValid !== 1'b1; i = i + 1) @(negedge clk);
      d = rdValid ? rdData : 8'hxx;
    end
  endtask
endmodule // rec_host_model

/* File: tb/rec_regulator_config_chk.sv */
// Purpose: port checks of the regulator config slice
// Assumes: one clock domain. Notes: attached by bind at the foot
`timescale 1ns/1ns
module rec_regulator_config_chk (
  input wire       clk,               // clock
  input wire       nrst,              // reset, low
  input wire       wrEn,              // write strobe
  input wire [7:0] addr,              // address
  input wire [7:0] wrData,            // write data
  input wire [7:0] rdData,            // read data
  input wire       rdValid,           // read valid
  input wire [9:0] regOutputPulldown, // discharge
  input wire [9:0] regPinOneEnable,   // pin drive
  input wire [3:0] buckPinOneEnable,  // pin drive
  input wire [9:0] regPinOneControl,  // mask
  input wire [3:0] buckPinOneControl  // mask
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  a_dis_rsvd: assert property (rdValid && $past(addr) == 8'h2E |-> rdData[7:6] == 2'b00)
    else $error("discharge top bits read nonzero");
  a_mask_rsvd: assert property (rdValid && $past(addr) == 8'h30 |-> rdData[7:6] == 2'b00)
    else $error("mask top bits read nonzero");
  a_src_rsvd: assert property (rdValid && $past(addr) == 8'h2C |-> rdData[7:2] == 6'h00)
    else $error("source spare bits read nonzero");
  a_low_dis_wr: assert property (wrEn && addr == 8'h2D |-> ##2
    regOutputPulldown[7:0] == $past(wrData, 2)) else $error("discharge write lost");
  a_low_mask_wr: assert property (wrEn && addr == 8'h2F |-> ##2
    regPinOneControl[7:0] == $past(wrData, 2)) else $error("mask write lost");
  a_buck_mask_wr: assert property (wrEn && addr == 8'h30 |-> ##2
    buckPinOneControl == $past(wrData[5:2], 2)) else $error("buck mask write lost");
  a_reg_gate: assert property ((regPinOneControl == 10'h000)[*3] |->
    regPinOneEnable == 10'h000) else $error("pin drives unmasked regulator");
  a_buck_gate: assert property ((buckPinOneControl == 4'h0)[*3] |->
    buckPinOneEnable == 4'h0) else $error("pin drives unmasked buck");
  cover property (wrEn && addr == 8'h2C);
  cover property (regPinOneEnable != 10'h000);
  cover property (rdValid && rdData == 8'h00);
endmodule // rec_regulator_config_chk
bind rec_regulator_config rec_regulator_config_chk chk_u (.*);

/* File: tb/testbench.sv */
// Purpose: self-checking bench of the regulator config slice
// Assumes: inputs move on the falling edge. Notes: pins settle within eight cycles
`timescale 1ns/1ns
module testbench;
  reg        clk = 1'b0, nrst = 1'b0, enablePinOne = 1'b0;
  reg  [3:0] voltageSelectPin = 4'h0;
  reg  [1:0] otpSource = 2'h2;
  reg  [7:0] otpDisLow = 8'hA5, otpDisHigh = 8'hFF, otpMaskLow = 8'h3C, otpMaskHigh = 8'hC6;
  wire       wrEn, rdEn, rdValid, reg1DefaultVoltageChoice, reg1UseAlternate;
  wire [7:0] addr, wrData, rdData;
  wire [9:0] regOutputPulldown, regPinOneEnable, regPinOneControl;
  wire [3:0] buckOutputPulldown, buckPinOneEnable, buckPinOneControl;
  integer    fails = 0, n_compared = 0, s;
  reg  [7:0] v;
  rec_host_model host_u (.*);
  rec_regulator_config dut_u (.*);
  initial forever #5 clk = ~clk;
  task finish_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [9:0] seen, input [9:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        fails = fails + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task rc(input [7:0] a, input [9:0] e);
    begin
      host_u.rd(a, v);
      chk("read data", {2'b00, v}, e);
    end
  endtask
  task settle;
    repeat (8) @(negedge clk);
  endtask
  initial begin
    #100000;
    fails = fails + 1;
    finish_test;
  end
  initial begin
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    rc(8'h2C, 10'h002);
    rc(8'h30, 10'h006);
    chk("discharge", regOutputPulldown, 10'h3A5);
    chk("buck discharge", {6'h00, buckOutputPulldown}, 10'h00F);
    chk("mask", regPinOneControl, 10'h23C);
    $display("test defaults done");
    host_u.wr(8'h2E, 8'hC0);
    rc(8'h2E, 10'h000);
    chk("buck discharge", {6'h00, buckOutputPulldown}, 10'h000);
    host_u.wr(8'h30, 8'hFF);
    rc(8'h30, 10'h03F);
    host_u.wr(8'h2D, 8'h5A);
    host_u.wr(8'h40, 8'hFF);
    rc(8'h40, 10'h000);
    rc(8'h2D, 10'h05A);
    chk("discharge", regOutputPulldown, 10'h05A);
    chk("buck mask", {6'h00, buckPinOneControl}, 10'h00F);
    host_u.wr(8'h2E, 8'h16);
    rc(8'h2E, 10'h016);
    chk("discharge", regOutputPulldown, 10'h25A);
    chk("buck discharge", {6'h00, buckOutputPulldown}, 10'h005);
    $display("test writes done");
    for (s = 0; s < 4; s = s + 1) begin
      host_u.wr(8'h2C, s[7:0]);
      voltageSelectPin = 4'h1 << s;
      settle;
      chk("choice", {8'h00, reg1DefaultVoltageChoice, reg1UseAlternate}, 10'h003);
      voltageSelectPin = ~voltageSelectPin;
      settle;
      chk("choice", {8'h00, reg1DefaultVoltageChoice, reg1UseAlternate}, 10'h000);
    end
    $display("test source done");
    host_u.wr(8'h2F, 8'h81);
    host_u.wr(8'h30, 8'h30);
    rc(8'h2F, 10'h081);
    enablePinOne = 1'b1;
    settle;
    chk("pin drive", regPinOneEnable, 10'h081);
    chk("buck drive", {6'h00, buckPinOneEnable}, 10'h00C);
    enablePinOne = 1'b0;
    settle;
    chk("pin drive", regPinOneEnable, 10'h000);
    host_u.wr(8'h2F, 8'h00);
    host_u.wr(8'h30, 8'h00);
    enablePinOne = 1'b1;
    settle;
    chk("pin drive", regPinOneEnable, 10'h000);
    chk("buck drive", {6'h00, buckPinOneEnable}, 10'h000);
    $display("test pin one done");
    nrst = 1'b0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    settle;
    rc(8'h2D, 10'h0A5);
    rc(8'h2C, 10'h002);
    chk("mask", regPinOneControl, 10'h23C);
    chk("pin drive", regPinOneEnable, 10'h23C);
    chk("choice", {8'h00, reg1DefaultVoltageChoice, reg1UseAlternate}, 10'h003);
    $display("test power-on reload done");
    finish_test;
  end
endmodule // testbench
